// File: logic/fsl_freq_stage_unit.sv
// Decided for this implementation: the address map and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
module fsl_freq_stage_unit
  import fsl_pkg::*;
#(
  parameter int CYCLE_CNT = CYCLE_CLKS
) (
  input  wire logic        mclk_in,
  input  wire logic        rst_b_in,
  input  wire logic [7:0]  address_in,
  input  wire logic        read_in,
  input  wire logic        write_in,
  input  wire logic [31:0] writedata_in,
  output logic [31:0]      readdata_out,
  output logic             waitrequest_out,
  input  wire logic        block_in,
  input  wire logic [23:0] freq_in,
  input  wire logic [31:0] time_ms_in,
  input  wire logic [2:0]  set_group_in,
  output logic             start_out,
  output logic             trip_out,
  output logic             blocked_out,
  output logic             ev_valid_out,
  output logic [2:0]       ev_code_out,
  output logic [31:0]      ev_time_out
);
  logic [14:0]   ctrl;
  logic [16:0]   setp;
  logic [18:0]   opdly;
  logic [18:0]   rldly;
  logic [3:0]    rsel;
  logic [31:0]   tick_cnt;
  logic          tick;
  logic          blk_s;
  logic          pick;
  fsl_state_type state;
  logic [18:0]   op_tmr;
  logic [18:0]   rel_tmr;
  logic          rel_run;
  logic [2:0]    flags;
  logic [5:0]    pend;
  logic [31:0]   pend_ts;
  logic [31:0]   cnt [3];
  logic [23:0]   pre_line [PRE_DEPTH];
  logic [31:0]   rec_ts [REC_DEPTH];
  logic [2:0]    rec_ev [REC_DEPTH];
  logic [3:0]    rec_grp [REC_DEPTH];
  logic [23:0]   rec_pre [REC_DEPTH];
  logic [23:0]   rec_flt [REC_DEPTH];
  logic [3:0]    wptr;
  logic [3:0]    rcount;
  logic [26:0]   div_rem;
  logic [26:0]   div_quo;
  logic [4:0]    div_step;
  logic [14:0]   ratio;
  logic          acc;
  logic          wr_go;
  logic          clr_go;
  logic          blk_eff;
  logic          live;
  logic [2:0]    next_flags;
  logic [5:0]    chg;
  logic [27:0]   div_try;
  logic [16:0]   hi_lim;
  logic [16:0]   lo_lim;

  assign acc    = (read_in | write_in) & ~waitrequest_out;
  assign wr_go  = write_in & ~waitrequest_out;
  assign clr_go = wr_go & (address_in == CTRL_ADDR) & writedata_in[CTL_CLR];
  // node mode: blocked variants force the block, off stops the stage
  assign blk_eff = blk_s | (ctrl[CTL_LN+:3] == LN_BLOCKED) | (ctrl[CTL_LN+:3] == LN_TESTBLK);
  assign live    = ctrl[CTL_EN] & (ctrl[CTL_LN+:3] != LN_OFF);
  assign hi_lim  = setp + HYST_MHZ;
  assign lo_lim  = setp - HYST_MHZ;

  // one wait state on every access keeps read data registered
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      waitrequest_out <= 1'b1;
    end else begin
      waitrequest_out <= ~((read_in | write_in) & waitrequest_out);
    end
  end

  // software registers; clear bit is a write-only pulse
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl  <= CTRL_RST;
      setp  <= SETP_RST;
      opdly <= OPDLY_RST;
      rldly <= RLDLY_RST;
      rsel  <= 4'h0;
    end else if (wr_go) begin
      case (address_in)
        CTRL_ADDR:  ctrl  <= writedata_in[14:0];
        SETP_ADDR:  setp  <= writedata_in[16:0];
        OPDLY_ADDR: opdly <= writedata_in[18:0];
        RLDLY_ADDR: rldly <= writedata_in[18:0];
        RSEL_ADDR:  rsel  <= writedata_in[3:0];
        default:    rsel  <= rsel;
      endcase
    end
  end

  // program cycle strobe, one clock every 5 ms
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tick_cnt <= 32'h0;
      tick     <= 1'b0;
    end else begin
      tick     <= (tick_cnt == 32'(CYCLE_CNT - 1));
      tick_cnt <= (tick_cnt == 32'(CYCLE_CNT - 1)) ? 32'h0 : tick_cnt + 32'h1;
    end
  end

  // block and pick-up are judged once per cycle and held
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      blk_s <= 1'b0;
      pick  <= 1'b0;
    end else if (tick) begin
      blk_s <= block_in;
      if (ctrl[CTL_UNDER]) begin
        pick <= pick ? (freq_in < 24'(hi_lim)) : (freq_in < 24'(setp));
      end else begin
        pick <= pick ? (freq_in > 24'(lo_lim)) : (freq_in > 24'(setp));
      end
    end
  end

  // stage sequencer; pick and blk_s were latched on the previous tick
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state   <= FSL_NORMAL;
      op_tmr  <= 19'h0;
      rel_tmr <= 19'h0;
      rel_run <= 1'b0;
    end else if (tick) begin
      case (state)
        FSL_NORMAL: begin
          if (live && pick && blk_eff) begin
            state <= FSL_BLKD;
          end else if (live && pick) begin
            state   <= FSL_START;
            rel_run <= 1'b0;
            op_tmr  <= rel_run ? op_tmr : 19'h0;
          end else if (rel_run) begin
            rel_tmr <= rel_tmr + 19'h1;
            if (rel_tmr + 19'h1 >= rldly) begin
              rel_run <= 1'b0;
              op_tmr  <= 19'h0;
            end
          end
        end
        FSL_START: begin
          if (!live || !pick || blk_eff) begin
            state   <= FSL_NORMAL;
            rel_run <= 1'b1;
            rel_tmr <= 19'h0;
          end else if (op_tmr + 19'h1 >= opdly) begin
            state  <= FSL_TRIP;
            op_tmr <= opdly;
          end else begin
            op_tmr <= op_tmr + 19'h1;
          end
        end
        FSL_TRIP: begin
          if (!live || !pick || blk_eff) begin
            state   <= FSL_NORMAL;
            rel_run <= 1'b1;
            rel_tmr <= 19'h0;
          end
        end
        FSL_BLKD: begin
          if (!live || !pick || !blk_eff) begin
            state <= FSL_NORMAL;
          end
        end
        default: state <= FSL_NORMAL;
      endcase
    end
  end

  // reported flags {blocked, trip, start}; force overrides the sequencer
  always_comb begin
    next_flags = {state == FSL_BLKD, state == FSL_TRIP, state == FSL_START};
    if (ctrl[CTL_FEN]) begin
      case (ctrl[CTL_FVAL+:2])
        COND_START: next_flags = 3'h1;
        COND_TRIP:  next_flags = 3'h2;
        COND_BLK:   next_flags = 3'h4;
        default:    next_flags = 3'h0;
      endcase
    end
    chg = {flags[2] & ~next_flags[2], ~flags[2] & next_flags[2],
           flags[1] & ~next_flags[1], ~flags[1] & next_flags[1],
           flags[0] & ~next_flags[0], ~flags[0] & next_flags[0]}; // bit n is event code n
  end

  // outputs drive relays and user logic directly
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      flags       <= 3'h0;
      start_out   <= 1'b0;
      trip_out    <= 1'b0;
      blocked_out <= 1'b0;
    end else begin
      flags       <= next_flags;
      start_out   <= next_flags[0];
      trip_out    <= next_flags[1];
      blocked_out <= next_flags[2];
    end
  end

  // several edges can coincide; they queue and leave one per clock
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pend         <= 6'h0;
      pend_ts      <= 32'h0;
      ev_valid_out <= 1'b0;
      ev_code_out  <= 3'h0;
      ev_time_out  <= 32'h0;
    end else begin
      ev_valid_out <= 1'b0;
      if (|(chg & ctrl[CTL_EVSEL+:6])) begin
        pend    <= pend | (chg & ctrl[CTL_EVSEL+:6]);
        pend_ts <= time_ms_in;
      end else if (|pend) begin
        for (int i = 5; i >= 0; i--) begin
          if (pend[i]) begin
            ev_code_out <= 3'(i);
          end
        end
        pend         <= pend & (pend - 6'h1);
        ev_valid_out <= 1'b1;
        ev_time_out  <= pend_ts;
      end
    end
  end

  // counters: an event in the clear cycle still counts once
  generate
    for (genvar g = 0; g < 3; g++) begin : g_cnt
      always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          cnt[g] <= 32'h0;
        end else if (~flags[g] & next_flags[g]) begin
          cnt[g] <= clr_go ? 32'h1 : cnt[g] + 32'h1;
        end else if (clr_go) begin
          cnt[g] <= 32'h0;
        end
      end
    end
  endgenerate

  // pre-trigger delay line, one frequency sample per program cycle
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < PRE_DEPTH; i++) begin
        pre_line[i] <= 24'h0;
      end
    end else if (tick) begin
      pre_line[0] <= freq_in;
      for (int i = 1; i < PRE_DEPTH; i++) begin
        pre_line[i] <= pre_line[i-1];
      end
    end
  end

  // operation ring: start on or trip on writes a record
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wptr   <= 4'h0;
      rcount <= 4'h0;
      for (int i = 0; i < REC_DEPTH; i++) begin
        rec_ts[i]  <= 32'h0;
        rec_ev[i]  <= 3'h0;
        rec_grp[i] <= 4'h0;
        rec_pre[i] <= 24'h0;
        rec_flt[i] <= 24'h0;
      end
    end else if (chg[0] | chg[2]) begin
      rec_ts[wptr]  <= time_ms_in;
      rec_ev[wptr]  <= chg[2] ? 3'h2 : 3'h0;
      rec_grp[wptr] <= {1'b0, set_group_in} + 4'h1;
      rec_pre[wptr] <= pre_line[PRE_DEPTH-1];
      rec_flt[wptr] <= freq_in;
      wptr   <= (wptr == 4'(REC_DEPTH - 1)) ? 4'h0 : wptr + 4'h1;
      rcount <= (rcount == 4'(REC_DEPTH)) ? rcount : rcount + 4'h1;
    end
  end

  // sequential divider: ratio = freq * 1000 / setting; a tick restarts it only once idle,
  // so short program cycles still let it finish
  assign div_try = {div_rem, div_quo[26]} - {11'h0, setp};
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_rem  <= 27'h0;
      div_quo  <= 27'h0;
      div_step <= 5'h0;
      ratio    <= 15'h0;
    end else if (tick && div_step == 5'h0) begin
      div_rem  <= 27'h0;
      div_quo  <= 27'(freq_in * RATIO_SCALE);
      div_step <= DIV_STEPS;
    end else if (div_step != 5'h0) begin
      div_step <= div_step - 5'h1;
      if (!div_try[27]) begin
        div_rem <= div_try[26:0];
        div_quo <= {div_quo[25:0], 1'b1};
      end else begin
        div_rem <= {div_rem[25:0], div_quo[26]};
        div_quo <= {div_quo[25:0], 1'b0};
      end
      if (div_step == 5'h1) begin
        ratio <= (setp == 17'h0 || {div_quo[25:0], ~div_try[27]} >= 27'(RATIO_MAX))
                 ? RATIO_MAX : 15'({div_quo[25:0], ~div_try[27]});
      end
    end
  end

  // read mux; unmapped addresses read as zero
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      readdata_out <= 32'h0;
    end else if (read_in && waitrequest_out) begin
      case (address_in)
        CTRL_ADDR:  readdata_out <= {17'h0, ctrl};
        SETP_ADDR:  readdata_out <= {15'h0, setp};
        OPDLY_ADDR: readdata_out <= {13'h0, opdly};
        RLDLY_ADDR: readdata_out <= {13'h0, rldly};
        STAT_ADDR:  readdata_out <= {25'h0, pick, 1'b0,
                                     ctrl[CTL_LNALW] ? ctrl[CTL_LN+:3] : LN_ON,
                                     flags[2] ? COND_BLK : flags[1] ? COND_TRIP
                                     : flags[0] ? COND_START : COND_NORMAL};
        RATIO_ADDR: readdata_out <= {17'h0, ratio};
        TREM_ADDR:  readdata_out <= flags[0] ? 32'(signed'({1'b0, opdly - op_tmr}))
                                    : 32'h0;
        EXPT_ADDR:  readdata_out <= {13'h0, opdly};
        CNTS_ADDR:  readdata_out <= cnt[0];
        CNTT_ADDR:  readdata_out <= cnt[1];
        CNTB_ADDR:  readdata_out <= cnt[2];
        RSEL_ADDR:  readdata_out <= {16'h0, rcount, wptr, 4'h0, rsel};
        RTS_ADDR:   readdata_out <= (rsel < 4'(REC_DEPTH)) ? rec_ts[rsel] : 32'h0;
        RINF_ADDR:  readdata_out <= (rsel < 4'(REC_DEPTH))
                                    ? {24'h0, rec_grp[rsel], 1'b0, rec_ev[rsel]} : 32'h0;
        RPRE_ADDR:  readdata_out <= (rsel < 4'(REC_DEPTH)) ? {8'h0, rec_pre[rsel]} : 32'h0;
        RFLT_ADDR:  readdata_out <= (rsel < 4'(REC_DEPTH)) ? {8'h0, rec_flt[rsel]} : 32'h0;
        default:    readdata_out <= 32'h0;
      endcase
    end
  end
endmodule : fsl_freq_stage_unit
`default_nettype wire

// File: logic/fsl_pkg.sv
package fsl_pkg;
  // register byte addresses on the avalon-mm slave
  localparam logic [7:0] CTRL_ADDR  = 8'h00;
  localparam logic [7:0] SETP_ADDR  = 8'h04;
  localparam logic [7:0] OPDLY_ADDR = 8'h08;
  localparam logic [7:0] RLDLY_ADDR = 8'h0C;
  localparam logic [7:0] STAT_ADDR  = 8'h10;
  localparam logic [7:0] RATIO_ADDR = 8'h14;
  localparam logic [7:0] TREM_ADDR  = 8'h18;
  localparam logic [7:0] EXPT_ADDR  = 8'h1C;
  localparam logic [7:0] CNTS_ADDR  = 8'h20;
  localparam logic [7:0] CNTT_ADDR  = 8'h24;
  localparam logic [7:0] CNTB_ADDR  = 8'h28;
  localparam logic [7:0] RSEL_ADDR  = 8'h2C;
  localparam logic [7:0] RTS_ADDR   = 8'h30;
  localparam logic [7:0] RINF_ADDR  = 8'h34;
  localparam logic [7:0] RPRE_ADDR  = 8'h38;
  localparam logic [7:0] RFLT_ADDR  = 8'h3C;
  // control field positions
  localparam int CTL_EN     = 0;
  localparam int CTL_UNDER  = 1;
  localparam int CTL_FEN    = 2;
  localparam int CTL_FVAL   = 3;
  localparam int CTL_LN     = 5;
  localparam int CTL_LNALW  = 8;
  localparam int CTL_EVSEL  = 9;
  localparam int CTL_CLR    = 31;
  // reset values
  localparam logic [14:0] CTRL_RST  = 15'h7E00;
  localparam logic [16:0] SETP_RST  = 17'h0C738;
  localparam logic [18:0] OPDLY_RST = 19'h00014;
  localparam logic [18:0] RLDLY_RST = 19'h00000;
  // timing: one program cycle is the 5 ms time step
  localparam longint CYCLE_NS   = 5000000;
  localparam longint MCLK_NS    = 50;
  localparam int     CYCLE_CLKS = int'(CYCLE_NS / MCLK_NS);
  localparam int     PRE_MS     = 20;
  localparam int     PRE_DEPTH  = (PRE_MS * 1000000) / int'(CYCLE_NS);
  localparam logic [16:0] HYST_MHZ = 17'h00014;
  localparam int     REC_DEPTH  = 12;
  localparam logic [14:0] RATIO_MAX = 15'h4E20;
  localparam logic [26:0] RATIO_SCALE = 27'h00003E8;
  localparam logic [4:0]  DIV_STEPS = 5'h1B;
  // reported condition and node behaviour codes
  localparam logic [1:0] COND_NORMAL = 2'h0;
  localparam logic [1:0] COND_START  = 2'h1;
  localparam logic [1:0] COND_TRIP   = 2'h2;
  localparam logic [1:0] COND_BLK    = 2'h3;
  localparam logic [2:0] LN_ON       = 3'h0;
  localparam logic [2:0] LN_BLOCKED  = 3'h1;
  localparam logic [2:0] LN_TEST     = 3'h2;
  localparam logic [2:0] LN_TESTBLK  = 3'h3;
  localparam logic [2:0] LN_OFF      = 3'h4;
  typedef enum logic [3:0] {
    FSL_NORMAL = 4'h1,
    FSL_START  = 4'h2,
    FSL_TRIP   = 4'h4,
    FSL_BLKD   = 4'h8
  } fsl_state_type;
endpackage : fsl_pkg

// File: bench/fsl_stage_checker.sv
`timescale 1ns/10ps
`default_nettype none
module fsl_stage_checker
  import fsl_pkg::*;
#(
  parameter int CYCLE_CNT = CYCLE_CLKS
) (
  input wire logic        mclk_in,
  input wire logic        rst_b_in,
  input wire logic [7:0]  address_in,
  input wire logic        read_in,
  input wire logic        write_in,
  input wire logic [31:0] writedata_in,
  input wire logic [31:0] readdata_out,
  input wire logic        waitrequest_out,
  input wire logic        block_in,
  input wire logic [23:0] freq_in,
  input wire logic [31:0] time_ms_in,
  input wire logic [2:0]  set_group_in,
  input wire logic        start_out,
  input wire logic        trip_out,
  input wire logic        blocked_out,
  input wire logic        ev_valid_out,
  input wire logic [2:0]  ev_code_out,
  input wire logic [31:0] ev_time_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  // bus answers after exactly one wait state, then rests high
  a_wait_answer: assert property ($rose(read_in || write_in) |=> !waitrequest_out)
    else $error("waitrequest did not drop one cycle after request");
  a_wait_single: assert property (!waitrequest_out |=> waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  a_unmapped_zero: assert property (read_in && !waitrequest_out && address_in >= 8'h40
    |-> readdata_out == 32'h0) else $error("unmapped read not zero");
  // states change only on the program tick, so a level holds a whole tick (8 clocks in sim)
  a_start_hold: assert property ($changed(start_out) |=> $stable(start_out)[*7])
    else $error("start changed within one program cycle");
  a_blk_exclusive: assert property (blocked_out |-> !start_out && !trip_out)
    else $error("blocked together with start or trip");
  a_trip_exclusive: assert property (trip_out |-> !start_out)
    else $error("start still set during trip");
  a_trip_after_start: assert property ($rose(trip_out) |-> $past(start_out))
    else $error("trip without preceding start");
  a_start_event: assert property ($rose(start_out)
    |-> ##[1:3] (ev_valid_out && ev_code_out == 3'h0)) else $error("no start on event");
  a_trip_event: assert property ($rose(trip_out)
    |-> ##[1:4] (ev_valid_out && ev_code_out == 3'h2)) else $error("no trip on event");
  a_blk_event: assert property ($rose(blocked_out)
    |-> ##[1:3] (ev_valid_out && ev_code_out == 3'h4)) else $error("no blocked event");
  a_code_range: assert property (ev_valid_out |-> ev_code_out <= 3'h5)
    else $error("event code out of range");
endmodule : fsl_stage_checker
bind fsl_freq_stage_unit fsl_stage_checker #(.CYCLE_CNT(CYCLE_CNT)) i_chk (
  .mclk_in(mclk_in), .rst_b_in(rst_b_in), .address_in(address_in), .read_in(read_in),
  .write_in(write_in), .writedata_in(writedata_in), .readdata_out(readdata_out),
  .waitrequest_out(waitrequest_out), .block_in(block_in), .freq_in(freq_in),
  .time_ms_in(time_ms_in), .set_group_in(set_group_in), .start_out(start_out),
  .trip_out(trip_out), .blocked_out(blocked_out), .ev_valid_out(ev_valid_out),
  .ev_code_out(ev_code_out), .ev_time_out(ev_time_out));
`default_nettype wire

// File: bench/fsl_far_side.sv
`timescale 1ns/10ps
`default_nettype none
module fsl_far_side #(
  parameter int LAG = 4
) (
  input wire logic         mclk_in,
  input wire logic         rst_b_in,
  input wire logic         blk_req_in,
  input wire logic         slow_in,
  input wire logic [23:0]  freq_req_in,
  input wire logic [31:0]  ts_req_in,
  input wire logic [2:0]   grp_req_in,
  output logic             block_out,
  output logic [23:0]      freq_out,
  output logic [31:0]      time_ms_out,
  output logic [2:0]       group_out
);
  logic [LAG-1:0] dly;
  // blocking matrix: prompt or some clocks late, still a tick ahead of expiry
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dly       <= '0;
      block_out <= 1'b0;
    end else begin
      dly       <= {dly[LAG-2:0], blk_req_in};
      block_out <= slow_in ? dly[LAG-1] : blk_req_in;
    end
  end
  // measured frequency, relay clock and active group follow the requests
  always_ff @(posedge mclk_in) begin
    freq_out    <= freq_req_in;
    time_ms_out <= ts_req_in;
    group_out   <= grp_req_in;
  end
endmodule : fsl_far_side
`default_nettype wire

// File: bench/frequency_stage_status_logger_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module frequency_stage_status_logger_tb_top;
  import fsl_pkg::*;
  localparam int CC = 8;
  logic mclk_in = 1'b0, rst_b_in = 1'b0, read_in = 1'b0, write_in = 1'b0;
  logic [7:0] address_in = 8'h00;
  logic [31:0] writedata_in = 32'h0, readdata_out, ev_time_out, time_ms_in, rdq;
  logic waitrequest_out, block_in, start_out, trip_out, blocked_out, ev_valid_out;
  logic [23:0] freq_in, flo, fhi;
  logic [2:0] ev_code_out, set_group_in;
  logic b_req = 1'b0, slow = 1'b0;
  logic [23:0] f_req = 24'h00C350;
  logic [31:0] ts = 32'h0000_1000;
  logic [2:0] grp = 3'h0;
  logic [15:0] rnd = 16'h001D;
  logic [34:0] evq[$];
  int mismatches = 0, tests_run = 0, cyc = 0, hit;
  fsl_freq_stage_unit #(.CYCLE_CNT(CC)) i_dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .address_in(address_in), .read_in(read_in), .write_in(write_in),
    .writedata_in(writedata_in), .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out), .block_in(block_in), .freq_in(freq_in),
    .time_ms_in(time_ms_in), .set_group_in(set_group_in), .start_out(start_out),
    .trip_out(trip_out), .blocked_out(blocked_out), .ev_valid_out(ev_valid_out),
    .ev_code_out(ev_code_out), .ev_time_out(ev_time_out));
  fsl_far_side i_far (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .blk_req_in(b_req),
    .slow_in(slow), .freq_req_in(f_req), .ts_req_in(ts), .grp_req_in(grp),
    .block_out(block_in), .freq_out(freq_in), .time_ms_out(time_ms_in),
    .group_out(set_group_in));
  always #25 mclk_in = ~mclk_in;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one avalon access; the request stands until waitrequest is sampled low
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    address_in   <= a;
    writedata_in <= d;
    read_in      <= ~wr;
    write_in     <= wr;
    do @(posedge mclk_in); while (waitrequest_out !== 1'b0);
    rdq = readdata_out;
    read_in  <= 1'b0;
    write_in <= 1'b0;
    @(posedge mclk_in);
  endtask : acc
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(rdq, e);
  endtask : rd
  task automatic ticks(input int n);
    repeat (n * CC) @(posedge mclk_in);
  endtask : ticks
  task automatic ev(input logic [2:0] c);
    evq.push_back({c, ts});
  endtask : ev
  // random frequency well clear of the pick-up and release thresholds
  task automatic fq(input logic hi);
    rnd = lfsr(rnd);
    f_req <= hi ? 24'd51100 + rnd[10:0] : 24'd50000 - rnd[10:0];
    if (hi) fhi = 24'd51100 + rnd[10:0];
    else flo = 24'd50000 - rnd[10:0];
  endtask : fq
  // every event must have been noted; its stamp is the time of the change
  always @(posedge mclk_in) begin
    if (ev_valid_out === 1'b1) begin
      hit = -1;
      foreach (evq[i]) if (hit < 0 && evq[i][34:32] === ev_code_out) hit = i;
      if (hit < 0) chk({29'h0, ev_code_out}, 32'hFFFFFFFF);
      else begin
        chk(ev_time_out, evq[hit][31:0]);
        evq.delete(hit);
      end
    end
  end
  // hang guard: far beyond the few hundred clocks the sequence needs
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  initial begin
    repeat (16) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    @(posedge mclk_in);
    fq(1'b0);
    rd(CTRL_ADDR, {17'h0, CTRL_RST});
    rd(SETP_ADDR, {15'h0, SETP_RST});
    rd(OPDLY_ADDR, {13'h0, OPDLY_RST});
    rd(RLDLY_ADDR, {13'h0, RLDLY_RST});
    acc(1'b1, STAT_ADDR, 32'hFF);
    acc(1'b1, 8'hFC, 32'h5A);
    rd(STAT_ADDR, 32'h0);
    rd(8'hFC, 32'h0);
    $display("register defaults done");
    grp <= rnd[2:0];
    acc(1'b1, OPDLY_ADDR, 32'h3);
    acc(1'b1, CTRL_ADDR, 32'h7E01);
    ticks(5);
    ev(3'h0);
    ev(3'h2);
    ev(3'h1);
    fq(1'b1);
    ticks(7);
    chk({31'h0, trip_out}, 32'h1);
    chk({31'h0, start_out}, 32'h0);
    rd(STAT_ADDR, {25'h0, 1'b1, 4'h0, COND_TRIP});
    rd(EXPT_ADDR, 32'h3);
    rd(CNTS_ADDR, 32'h1);
    rd(CNTT_ADDR, 32'h1);
    rd(RSEL_ADDR, 32'h2200);
    acc(1'b1, RSEL_ADDR, 32'h0);
    rd(RTS_ADDR, ts);
    rd(RINF_ADDR, {24'h0, 4'(grp) + 4'h1, 4'h0});
    rd(RPRE_ADDR, {8'h0, flo});
    rd(RFLT_ADDR, {8'h0, fhi});
    ts <= ts + 32'h100;
    @(posedge mclk_in);
    ev(3'h3);
    fq(1'b0);
    ticks(4);
    chk({31'h0, trip_out}, 32'h0);
    rd(TREM_ADDR, 32'h0);
    chk(evq.size(), 32'h0);
    $display("start and trip done");
    ts <= ts + 32'h100;
    acc(1'b1, OPDLY_ADDR, 32'h6);
    ev(3'h0);
    ev(3'h1);
    ev(3'h4);
    ev(3'h5);
    fq(1'b1);
    ticks(3);
    chk({31'h0, start_out}, 32'h1);
    slow <= 1'b1;
    b_req <= 1'b1;
    ticks(3);
    chk({29'h0, start_out, trip_out, blocked_out}, 32'h0);
    ticks(6);
    chk({31'h0, trip_out}, 32'h0);
    chk({31'h0, blocked_out}, 32'h1);
    fq(1'b0);
    b_req <= 1'b0;
    ticks(3);
    slow <= 1'b0;
    chk(evq.size(), 32'h0);
    $display("block during start done");
    ts <= ts + 32'h100;
    b_req <= 1'b1;
    ticks(2);
    ev(3'h4);
    fq(1'b1);
    ticks(3);
    chk({30'h0, blocked_out, start_out}, 32'h2);
    acc(1'b0, STAT_ADDR, 32'h0);
    chk({30'h0, rdq[1:0]}, {30'h0, COND_BLK});
    rd(CNTB_ADDR, 32'h2);
    ev(3'h5);
    fq(1'b0);
    b_req <= 1'b0;
    ticks(3);
    chk({31'h0, blocked_out}, 32'h0);
    chk(evq.size(), 32'h0);
    $display("blocked pick-up done");
    ts <= ts + 32'h100;
    acc(1'b1, CTRL_ADDR, 32'h80002A01);
    rd(CTRL_ADDR, 32'h2A01);
    rd(CNTS_ADDR, 32'h0);
    acc(1'b1, OPDLY_ADDR, 32'h2);
    ev(3'h0);
    ev(3'h2);
    fq(1'b1);
    ticks(6);
    chk({31'h0, trip_out}, 32'h1);
    fq(1'b0);
    ticks(4);
    rd(CNTT_ADDR, 32'h1);
    chk(evq.size(), 32'h0);
    $display("event select and clear done");
    ticks(6);
    rd(RATIO_ADDR, 32'((64'(flo) * 64'd1000) / 64'(SETP_RST)));
    acc(1'b1, CTRL_ADDR, 32'h7F41);
    rd(STAT_ADDR, {27'h0, LN_TEST, COND_NORMAL});
    $display("ratio and node mode done");
    stop_test();
  end
endmodule : frequency_stage_status_logger_tb_top
`default_nettype wire
